/* hdl/motion_ready_and_start_accept.sv */
// motion ready handshake, start-accepted flags and servo loop select logic
`timescale 1ns/1ps
`default_nettype none
module motion_ready_and_start_accept #(
    parameter int AXES = motion_ready_pkg::AXES_MAX
) (
    // clock and reset
    input wire logic sys_clk,
    input wire logic rst_n,
    // axi4-lite slave
    input wire logic [7:0] s_axi_awaddr,
    input wire logic s_axi_awvalid,
    output logic s_axi_awready,
    input wire logic [31:0] s_axi_wdata,
    input wire logic [3:0] s_axi_wstrb,
    input wire logic s_axi_wvalid,
    output logic s_axi_wready,
    output logic [1:0] s_axi_bresp,
    output logic s_axi_bvalid,
    input wire logic s_axi_bready,
    input wire logic [7:0] s_axi_araddr,
    input wire logic s_axi_arvalid,
    output logic s_axi_arready,
    output logic [31:0] s_axi_rdata,
    output logic [1:0] s_axi_rresp,
    output logic s_axi_rvalid,
    input wire logic s_axi_rready,
    // run switch pin
    input wire logic runSwitch,
    // per-axis events from axis control
    input wire logic [AXES-1:0] servoStartEv,
    input wire logic [AXES-1:0] positioningDone,
    input wire logic [AXES-1:0] stopMidway,
    input wire logic [AXES-1:0] speedZeroHalt,
    input wire logic [AXES-1:0] forward_jog_cmd,
    input wire logic [AXES-1:0] reverse_jog_cmd,
    input wire logic [AXES-1:0] axisMoving,
    input wire logic [2:0] handwheel_enable_flags,
    input wire logic [AXES-1:0] handwheelAxisMap,
    input wire logic [AXES-1:0] valueChangeBusy,
    // amplifier status pins
    input wire logic [AXES-1:0] ampStarted,
    input wire logic [AXES-1:0] cableBreak,
    input wire logic [AXES-1:0] ampPowerLost,
    // amplifier commands
    output logic [AXES-1:0] gainAltSel,
    output logic [AXES-1:0] fullyClosedReq,
    // motion control outputs and the aux code pending input
    output logic controller_ready_flag,
    output logic motion_ready_done_flag,
    output logic motionPermit,
    output logic auxCodeClear,
    output logic autoProgStart,
    output logic decelStopAll,
    output logic programHalt,
    output logic realOutputsOff,
    output logic auxCodeOutStatus,
    output logic readyRiseError,
    input wire logic auxCodePending
);
    logic sysClk;
    assign sysClk = sys_clk;
    // ****************************************************************
    // input synchronisers
    // ****************************************************************
    logic runMeta_r, runSync_r;
    logic [AXES-1:0] startedMeta_r, startedSync_r;
    logic [AXES-1:0] breakMeta_r, breakSync_r;
    logic [AXES-1:0] pwrMeta_r, pwrSync_r;
    always_ff @(posedge sysClk or negedge rst_n) begin
        if (!rst_n) begin
            runMeta_r <= 1'b0;
            runSync_r <= 1'b0;
            startedMeta_r <= '0;
            startedSync_r <= '0;
            breakMeta_r <= '0;
            breakSync_r <= '0;
            pwrMeta_r <= '0;
            pwrSync_r <= '0;
        end else begin
            runMeta_r <= runSwitch;
            runSync_r <= runMeta_r;
            startedMeta_r <= ampStarted;
            startedSync_r <= startedMeta_r;
            breakMeta_r <= cableBreak;
            breakSync_r <= breakMeta_r;
            pwrMeta_r <= ampPowerLost;
            pwrSync_r <= pwrMeta_r;
        end
    end

    // ****************************************************************
    // axi4-lite slave
    // ****************************************************************
    logic [31:0] ctrl_r, readyWord_r, gainSel_r, loopSel_r, param_r;
    logic [7:0] awAddr_r;
    logic [31:0] wData_r;
    logic awHave_r, wHave_r;
    logic wrFire;
    assign wrFire = awHave_r && wHave_r && !s_axi_bvalid;
    always_ff @(posedge sysClk or negedge rst_n) begin
        if (!rst_n) begin
            awHave_r <= 1'b0;
            wHave_r <= 1'b0;
            awAddr_r <= 8'h00;
            wData_r <= 32'h0000_0000;
            s_axi_awready <= 1'b0;
            s_axi_wready <= 1'b0;
            s_axi_bvalid <= 1'b0;
            s_axi_bresp <= motion_ready_pkg::RESP_OKAY;
        end else begin
            s_axi_awready <= !awHave_r && !s_axi_awready && s_axi_awvalid;
            s_axi_wready <= !wHave_r && !s_axi_wready && s_axi_wvalid;
            if (s_axi_awvalid && s_axi_awready) begin
                awHave_r <= 1'b1;
                awAddr_r <= s_axi_awaddr;
            end
            if (s_axi_wvalid && s_axi_wready) begin
                wHave_r <= 1'b1;
                wData_r <= s_axi_wdata;
            end
            if (wrFire) begin
                awHave_r <= 1'b0;
                wHave_r <= 1'b0;
                s_axi_bvalid <= 1'b1;
                s_axi_bresp <= wrOk(awAddr_r, controller_ready_flag) ?
                    motion_ready_pkg::RESP_OKAY : motion_ready_pkg::RESP_SLVERR;
            end else if (s_axi_bvalid && s_axi_bready) begin
                s_axi_bvalid <= 1'b0;
            end
        end
    end

    // writable offsets; parameter store refuses while ready is on
    function automatic logic wrOk(input logic [7:0] a, input logic rdy);
        case (a)
            motion_ready_pkg::OFF_CTRL, motion_ready_pkg::OFF_READY_WORD,
            motion_ready_pkg::OFF_GAIN_SEL, motion_ready_pkg::OFF_LOOP_SEL: wrOk = 1'b1;
            motion_ready_pkg::OFF_PARAM: wrOk = !rdy;
            default: wrOk = 1'b0;
        endcase
    endfunction : wrOk

    function automatic logic [31:0] merge(input logic [31:0] o, input logic [31:0] d,
                                          input logic [3:0] s);
        for (int i = 0; i < 4; i++) begin
            if (s[i]) begin
                o[i*8 +: 8] = d[i*8 +: 8];
            end
        end
        merge = o;
    endfunction : merge

    logic [3:0] wStrb_r;
    always_ff @(posedge sysClk or negedge rst_n) begin
        if (!rst_n) begin
            wStrb_r <= 4'h0;
        end else if (s_axi_wvalid && s_axi_wready) begin
            wStrb_r <= s_axi_wstrb;
        end
    end

    logic errClr;
    assign errClr = wrFire && awAddr_r == motion_ready_pkg::OFF_CTRL &&
                    wStrb_r[0] && wData_r[motion_ready_pkg::CTRL_ERR_CLR];
    always_ff @(posedge sysClk or negedge rst_n) begin
        if (!rst_n) begin
            ctrl_r <= motion_ready_pkg::CTRL_RESET;
            readyWord_r <= 32'h0000_0000;
            gainSel_r <= 32'h0000_0000;
            loopSel_r <= 32'h0000_0000;
            param_r <= 32'h0000_0000;
        end else if (wrFire) begin
            case (awAddr_r)
                motion_ready_pkg::OFF_CTRL: ctrl_r <= merge(ctrl_r, wData_r, wStrb_r) &
                                                      32'h0000_0007;
                motion_ready_pkg::OFF_READY_WORD: readyWord_r <= merge(readyWord_r, wData_r,
                                                                       wStrb_r);
                motion_ready_pkg::OFF_GAIN_SEL: gainSel_r <= merge(gainSel_r, wData_r, wStrb_r);
                motion_ready_pkg::OFF_LOOP_SEL: loopSel_r <= merge(loopSel_r, wData_r, wStrb_r);
                motion_ready_pkg::OFF_PARAM: begin
                    if (!controller_ready_flag) begin
                        param_r <= merge(param_r, wData_r, wStrb_r);
                    end
                end
                default: ;
            endcase
        end
    end

    logic [31:0] startAcc_r, loopAct_r;
    logic pending_r;
    always_ff @(posedge sysClk or negedge rst_n) begin
        if (!rst_n) begin
            s_axi_arready <= 1'b0;
            s_axi_rvalid <= 1'b0;
            s_axi_rdata <= 32'h0000_0000;
            s_axi_rresp <= motion_ready_pkg::RESP_OKAY;
        end else begin
            s_axi_arready <= !s_axi_arready && !s_axi_rvalid && s_axi_arvalid;
            if (s_axi_arvalid && s_axi_arready) begin
                s_axi_rvalid <= 1'b1;
                s_axi_rresp <= motion_ready_pkg::RESP_OKAY;
                case (s_axi_araddr)
                    motion_ready_pkg::OFF_CTRL: s_axi_rdata <= ctrl_r;
                    motion_ready_pkg::OFF_READY_WORD: s_axi_rdata <= readyWord_r;
                    motion_ready_pkg::OFF_STATUS: s_axi_rdata <= {28'h0, pending_r,
                        auxCodeOutStatus, motion_ready_done_flag, controller_ready_flag};
                    motion_ready_pkg::OFF_GAIN_SEL: s_axi_rdata <= gainSel_r;
                    motion_ready_pkg::OFF_LOOP_SEL: s_axi_rdata <= loopSel_r;
                    motion_ready_pkg::OFF_START_ACC: s_axi_rdata <= startAcc_r;
                    motion_ready_pkg::OFF_LOOP_ACT: s_axi_rdata <= loopAct_r;
                    motion_ready_pkg::OFF_PARAM: s_axi_rdata <= param_r;
                    motion_ready_pkg::OFF_ERR: s_axi_rdata <= {31'h0, readyRiseError};
                    default: begin
                        s_axi_rdata <= 32'h0000_0000;
                        s_axi_rresp <= motion_ready_pkg::RESP_SLVERR;
                    end
                endcase
            end else if (s_axi_rvalid && s_axi_rready) begin
                s_axi_rvalid <= 1'b0;
            end
        end
    end

    // ****************************************************************
    // controller ready arming
    // ****************************************************************
    logic runPrev_r, bitPrev_r, readyPrev_r, testPrev_r;
    logic altMode, testMode, readySet, readyClr;
    assign altMode = ctrl_r[motion_ready_pkg::CTRL_ALT_MODE];
    assign testMode = ctrl_r[motion_ready_pkg::CTRL_TEST];
    // runPrev_r resets to stop, so a switch already at run on release reads as a rise
    always_comb begin
        readySet = 1'b0;
        readyClr = 1'b0;
        if (!runSync_r) begin
            readyClr = 1'b1;
        end else if (!altMode) begin
            readySet = !runPrev_r;
        end else begin
            readySet = readyWord_r[0] && !bitPrev_r;
            readyClr = !readyWord_r[0] && bitPrev_r;
        end
    end

    always_ff @(posedge sysClk or negedge rst_n) begin
        if (!rst_n) begin
            controller_ready_flag <= 1'b0;
            runPrev_r <= 1'b0;
            bitPrev_r <= 1'b0;
        end else begin
            runPrev_r <= runSync_r;
            bitPrev_r <= readyWord_r[0];
            if (readyClr) begin
                controller_ready_flag <= 1'b0;
            end else if (readySet) begin
                controller_ready_flag <= 1'b1;
            end
        end
    end

    // ****************************************************************
    // ready edge actions
    // ****************************************************************
    logic rise, fall, testEnd;
    assign rise = controller_ready_flag && !readyPrev_r;
    assign fall = !controller_ready_flag && readyPrev_r;
    assign testEnd = testPrev_r && !testMode;
    always_ff @(posedge sysClk or negedge rst_n) begin
        if (!rst_n) begin
            readyPrev_r <= 1'b0;
            testPrev_r <= 1'b0;
            pending_r <= 1'b0;
            motion_ready_done_flag <= 1'b0;
            auxCodeClear <= 1'b0;
            autoProgStart <= 1'b0;
            decelStopAll <= 1'b0;
            programHalt <= 1'b0;
            realOutputsOff <= 1'b0;
            readyRiseError <= 1'b0;
        end else begin
            readyPrev_r <= controller_ready_flag;
            testPrev_r <= testMode;
            auxCodeClear <= 1'b0;
            autoProgStart <= 1'b0;
            decelStopAll <= 1'b0;
            programHalt <= 1'b0;
            if (errClr) begin
                readyRiseError <= 1'b0;
            end
            if (fall) begin
                pending_r <= 1'b0;
                motion_ready_done_flag <= 1'b0;
                decelStopAll <= 1'b1;
                programHalt <= 1'b1;
                realOutputsOff <= 1'b1;
            end else if ((rise || (pending_r && testEnd)) && testMode) begin
                pending_r <= 1'b1;
            end else if (rise || (pending_r && testEnd && controller_ready_flag)) begin
                pending_r <= 1'b0;
                if (|axisMoving) begin
                    readyRiseError <= 1'b1; // set wins over clear
                end else begin
                    auxCodeClear <= 1'b1;
                    motion_ready_done_flag <= 1'b1;
                    autoProgStart <= 1'b1;
                    realOutputsOff <= 1'b0;
                end
            end
        end
    end

    always_ff @(posedge sysClk or negedge rst_n) begin
        if (!rst_n) begin
            motionPermit <= 1'b0;
            auxCodeOutStatus <= 1'b0;
        end else begin
            motionPermit <= controller_ready_flag && !testMode;
            auxCodeOutStatus <= ctrl_r[motion_ready_pkg::CTRL_FIN_SEL] &&
                                auxCodePending;
        end
    end

    // ****************************************************************
    // per-axis amplifier commands and start-accepted flags
    // ****************************************************************
    // axes past the configured count stay zero; the small variant uses AXES = 8
    logic [AXES-1:0] hwEn, levelSrc, levelOwn_r;
    assign hwEn = (|handwheel_enable_flags) ? handwheelAxisMap : '0;
    // jog, handwheel and value change hold the flag until they end and the axis rests
    assign levelSrc = forward_jog_cmd | reverse_jog_cmd | hwEn | valueChangeBusy;
    always_ff @(posedge sysClk or negedge rst_n) begin
        if (!rst_n) begin
            gainAltSel <= '0;
            fullyClosedReq <= '0;
            startAcc_r <= 32'h0000_0000;
            levelOwn_r <= '0;
        end else begin
            gainAltSel <= gainSel_r[AXES-1:0];
            for (int n = 0; n < AXES; n++) begin
                if (breakSync_r[n] || pwrSync_r[n]) begin
                    fullyClosedReq[n] <= 1'b0;
                end else if (startedSync_r[n]) begin
                    fullyClosedReq[n] <= loopSel_r[n];
                end
                if (servoStartEv[n] || levelSrc[n]) begin
                    startAcc_r[n] <= 1'b1;
                end else if (!speedZeroHalt[n] && (positioningDone[n] || stopMidway[n] ||
                             (levelOwn_r[n] && !axisMoving[n]))) begin
                    startAcc_r[n] <= 1'b0;
                end
                if (levelSrc[n]) begin
                    levelOwn_r[n] <= 1'b1;
                end else if (servoStartEv[n] || !axisMoving[n]) begin
                    levelOwn_r[n] <= 1'b0;
                end
            end
        end
    end

    assign loopAct_r = 32'(fullyClosedReq);
endmodule : motion_ready_and_start_accept
`default_nettype wire

/* inc/motion_ready_pkg.sv */
// package: register map and constants of the ready and start-accept block
package motion_ready_pkg;
    localparam int AXES_MAX = 32;
    localparam int AXES_SMALL = 8;
    localparam logic [7:0] OFF_CTRL = 8'h00;
    localparam logic [7:0] OFF_READY_WORD = 8'h04;
    localparam logic [7:0] OFF_STATUS = 8'h08;
    localparam logic [7:0] OFF_GAIN_SEL = 8'h0c;
    localparam logic [7:0] OFF_LOOP_SEL = 8'h10;
    localparam logic [7:0] OFF_START_ACC = 8'h14;
    localparam logic [7:0] OFF_LOOP_ACT = 8'h18;
    localparam logic [7:0] OFF_PARAM = 8'h1c;
    localparam logic [7:0] OFF_ERR = 8'h20;
    localparam int CTRL_ALT_MODE = 0;
    localparam int CTRL_TEST = 1;
    localparam int CTRL_FIN_SEL = 2;
    localparam int CTRL_ERR_CLR = 3;
    localparam int ST_READY = 0;
    localparam int ST_DONE = 1;
    localparam int ST_AUX_OUT = 2;
    localparam int ST_PENDING = 3;
    localparam logic [1:0] RESP_OKAY = 2'b00;
    localparam logic [1:0] RESP_SLVERR = 2'b10;
    localparam logic [31:0] CTRL_RESET = 32'h0000_0000;
endpackage : motion_ready_pkg

/* bench/axis_side_model.sv */
// partner model: axis control and amplifier side of the block
`timescale 1ns/1ps
`default_nettype none
module axis_side_model #(
    parameter int AXES = 8,
    parameter int BOOT = 60,
    parameter int MOVE = 20
) (
    // clock and reset
    input wire logic sysClk,
    input wire logic rst_n,
    // move request
    input wire logic [AXES-1:0] goReq,
    // axis and amplifier status
    output logic [AXES-1:0] servoStartEv,
    output logic [AXES-1:0] positioningDone,
    output logic [AXES-1:0] axisMoving,
    output logic [AXES-1:0] ampStarted
);
    int bootCnt_r;
    int moveCnt_r;
    logic [AXES-1:0] movAxes_r;
    // amplifiers stay in start-up for a while after reset
    always_ff @(posedge sysClk or negedge rst_n) begin
        if (!rst_n) begin
            bootCnt_r <= 0;
        end else if (bootCnt_r < BOOT) begin
            bootCnt_r <= bootCnt_r + 1;
        end
    end
    assign ampStarted = (bootCnt_r >= BOOT) ? '1 : '0;
    // one move at a time: start pulse, busy level, completion pulse
    always_ff @(posedge sysClk or negedge rst_n) begin
        if (!rst_n) begin
            moveCnt_r <= 0;
            movAxes_r <= '0;
        end else if (goReq != '0) begin
            moveCnt_r <= MOVE;
            movAxes_r <= goReq;
        end else if (moveCnt_r > 0) begin
            moveCnt_r <= moveCnt_r - 1;
        end
    end
    assign servoStartEv = goReq;
    assign axisMoving = (moveCnt_r > 0) ? movAxes_r : '0;
    assign positioningDone = (moveCnt_r == 1) ? movAxes_r : '0;
endmodule : axis_side_model
`default_nettype wire

/* bench/motion_ready_checker.sv */
// checker: assertions on the ready handshake and loop select ports
`timescale 1ns/1ps
`default_nettype none
module motion_ready_checker #(
    parameter int AXES = 8
) (
    // clock and reset
    input wire logic sys_clk,
    input wire logic rst_n,
    // axis and amplifier side
    input wire logic [AXES-1:0] axisMoving,
    input wire logic [AXES-1:0] ampStarted,
    input wire logic [AXES-1:0] cableBreak,
    input wire logic [AXES-1:0] fullyClosedReq,
    input wire logic auxCodePending,
    // ready handshake outputs
    input wire logic controller_ready_flag,
    input wire logic motion_ready_done_flag,
    input wire logic motionPermit,
    input wire logic auxCodeClear,
    input wire logic autoProgStart,
    input wire logic decelStopAll,
    input wire logic programHalt,
    input wire logic realOutputsOff,
    input wire logic auxCodeOutStatus,
    input wire logic readyRiseError
);
    // ********************
    // assertions
    // ********************
    default clocking cb @(posedge sys_clk); endclocking
    default disable iff (!rst_n);
    sequence readyFall;
        $fell(controller_ready_flag);
    endsequence
    sequence fallActions;
        !motion_ready_done_flag && programHalt && decelStopAll && realOutputsOff;
    endsequence
    sequence riseWhileMoving;
        $rose(controller_ready_flag) && (axisMoving != '0);
    endsequence
    AST_FALL_ACTIONS: assert property (readyFall |=> fallActions)
        else $error("ready fall actions missing");
    AST_RISE_ACTIONS: assert property ($rose(motion_ready_done_flag) |->
        auxCodeClear && autoProgStart && controller_ready_flag)
        else $error("ready rise actions missing");
    AST_RISE_ERROR: assert property (riseWhileMoving |=>
        readyRiseError && !motion_ready_done_flag)
        else $error("rise with moving axis not refused");
    AST_NO_PERMIT: assert property (!controller_ready_flag [*2] |-> !motionPermit)
        else $error("motion permitted without ready");
    AST_AUX_IDLE: assert property (!auxCodePending [*2] |-> !auxCodeOutStatus)
        else $error("aux status without pending code");
    AST_BREAK_SEMI: assert property ((cableBreak != '0) [*6] |->
        (fullyClosedReq & $past(cableBreak, 5)) == '0)
        else $error("broken axis still fully closed");
    AST_BOOT_HOLD: assert property ((ampStarted == '0) [*4] |-> $stable(fullyClosedReq))
        else $error("loop changed before start-up");
    AST_RESET_CLEAR: assert property ($rose(rst_n) |->
        !controller_ready_flag && !motion_ready_done_flag && fullyClosedReq == '0)
        else $error("flags not cleared by reset");
endmodule : motion_ready_checker
bind motion_ready_and_start_accept motion_ready_checker #(.AXES(AXES)) checkerInst (
    .sys_clk, .rst_n, .axisMoving, .ampStarted, .cableBreak, .fullyClosedReq,
    .auxCodePending, .controller_ready_flag, .motion_ready_done_flag, .motionPermit,
    .auxCodeClear, .autoProgStart, .decelStopAll, .programHalt, .realOutputsOff,
    .auxCodeOutStatus, .readyRiseError
);
`default_nettype wire

/* bench/test_motion_ready_and_start_accept.sv */
// testbench: ready handshake, start-accepted flags and loop select
`timescale 1ns/1ps
`default_nettype none
module test_motion_ready_and_start_accept;
    localparam int AXES = 8;
    localparam logic [7:0] aStat = motion_ready_pkg::OFF_STATUS;
    localparam logic [7:0] aStart = motion_ready_pkg::OFF_START_ACC;
    localparam logic [7:0] aCtrl = motion_ready_pkg::OFF_CTRL;
    localparam logic [7:0] aWord = motion_ready_pkg::OFF_READY_WORD;
    localparam logic [1:0] rOk = motion_ready_pkg::RESP_OKAY;
    localparam logic [1:0] rErr = motion_ready_pkg::RESP_SLVERR;
    logic sysClk = 1'b0, rst_n = 1'b0, runSwitch = 1'b0, auxCodePending = 1'b0;
    logic s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0, s_axi_bready = 1'b0;
    logic s_axi_arvalid = 1'b0, s_axi_rready = 1'b0;
    logic [7:0] s_axi_awaddr = '0, s_axi_araddr = '0;
    logic [31:0] s_axi_wdata = '0, s_axi_rdata;
    logic [3:0] s_axi_wstrb = 4'hf;
    logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
    logic [1:0] s_axi_bresp, s_axi_rresp;
    logic [2:0] handwheel_enable_flags = '0;
    logic [AXES-1:0] goReq = '0, stopMidway = '0, speedZeroHalt = '0, tbMoving = '0;
    logic [AXES-1:0] forward_jog_cmd = '0, reverse_jog_cmd = '0, handwheelAxisMap = '0;
    logic [AXES-1:0] valueChangeBusy = '0, cableBreak = '0, ampPowerLost = '0;
    logic [AXES-1:0] servoStartEv, positioningDone, pMoving, ampStarted, gainAltSel;
    logic [AXES-1:0] fullyClosedReq;
    wire [AXES-1:0] axisMoving;
    logic controller_ready_flag, motion_ready_done_flag, motionPermit, auxCodeClear;
    logic autoProgStart, decelStopAll, programHalt, realOutputsOff, auxCodeOutStatus;
    logic readyRiseError;
    logic [1:0] expB[$];
    logic [33:0] expR[$];
    int badCount = 0, nChecks = 0, seed = 32'h8307fa85;
    logic [31:0] rnd;
    assign axisMoving = pMoving | tbMoving;
    always #5 sysClk = ~sysClk;
    motion_ready_and_start_accept #(.AXES(AXES)) uut (
        .sys_clk(sysClk), .rst_n, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready, .s_axi_wdata,
        .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid,
        .s_axi_bready, .s_axi_araddr, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata,
        .s_axi_rresp, .s_axi_rvalid, .s_axi_rready, .runSwitch, .servoStartEv,
        .positioningDone, .stopMidway, .speedZeroHalt, .forward_jog_cmd, .reverse_jog_cmd,
        .axisMoving, .handwheel_enable_flags, .handwheelAxisMap, .valueChangeBusy,
        .ampStarted, .cableBreak, .ampPowerLost, .gainAltSel, .fullyClosedReq,
        .controller_ready_flag, .motion_ready_done_flag, .motionPermit, .auxCodeClear,
        .autoProgStart, .decelStopAll, .programHalt, .realOutputsOff, .auxCodeOutStatus,
        .readyRiseError, .auxCodePending
    );
    axis_side_model #(.AXES(AXES)) partner (
        .sysClk, .rst_n, .goReq, .servoStartEv, .positioningDone, .axisMoving(pMoving),
        .ampStarted
    );
    // ********************
    // bus tasks and checks
    // ********************
    task automatic chk(input logic [33:0] seen, input logic [33:0] exp);
        nChecks++;
        if (seen !== exp) begin
            badCount++;
            $display("wrong value at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask : chk
    task automatic cyc(input int n);
        repeat (n) @(posedge sysClk);
    endtask : cyc
    task automatic axw(input logic [7:0] a, input logic [31:0] d, input logic [1:0] r);
        expB.push_back(r);
        @(posedge sysClk);
        s_axi_awaddr <= a;
        s_axi_wdata <= d;
        s_axi_awvalid <= 1'b1;
        s_axi_wvalid <= 1'b1;
        s_axi_bready <= 1'b1;
        do begin
            @(posedge sysClk);
            if (s_axi_awvalid && s_axi_awready) s_axi_awvalid <= 1'b0;
            if (s_axi_wvalid && s_axi_wready) s_axi_wvalid <= 1'b0;
        end while (!s_axi_bvalid);
        s_axi_bready <= 1'b0;
    endtask : axw
    task automatic axr(input logic [7:0] a, input logic [31:0] d, input logic [1:0] r);
        expR.push_back({r, d});
        @(posedge sysClk);
        s_axi_araddr <= a;
        s_axi_arvalid <= 1'b1;
        s_axi_rready <= 1'b1;
        do begin
            @(posedge sysClk);
            if (s_axi_arvalid && s_axi_arready) s_axi_arvalid <= 1'b0;
        end while (!s_axi_rvalid);
        s_axi_rready <= 1'b0;
    endtask : axr
    task automatic closeOut;
        $display("checks %0d mismatches %0d", nChecks, badCount);
        if (badCount == 0 && nChecks > 0) begin
            $display("Result: passed");
        end else begin
            $display("Result: failed");
        end
        $finish;
    endtask : closeOut
    // responses are matched against the oldest note in each queue
    always @(posedge sysClk) begin
        if (s_axi_bvalid && s_axi_bready) chk(s_axi_bresp, expB.pop_front());
        if (s_axi_rvalid && s_axi_rready) chk({s_axi_rresp, s_axi_rdata}, expR.pop_front());
    end
    initial begin
        cyc(20000);
        badCount++;
        closeOut();
    end
    // ********************
    // scenarios
    // ********************
    initial begin
        cyc(16);
        rst_n <= 1'b1;
        axw(motion_ready_pkg::OFF_LOOP_SEL, 32'hff, rOk);
        cyc(4);
        chk(fullyClosedReq, 8'h00);
        cyc(70);
        axw(motion_ready_pkg::OFF_LOOP_SEL, 32'h5a, rOk);
        cyc(4);
        chk(fullyClosedReq, 8'h5a);
        cableBreak <= 8'h02;
        cyc(8);
        chk(fullyClosedReq, 8'h58);
        cableBreak <= 8'h00;
        ampPowerLost <= 8'h08;
        cyc(8);
        chk(fullyClosedReq, 8'h52);
        ampPowerLost <= 8'h00;
        for (int i = 0; i < 2; i++) begin
            rnd = $random(seed);
            axw(motion_ready_pkg::OFF_GAIN_SEL, rnd, rOk);
            cyc(3);
            chk(gainAltSel, rnd[7:0]);
        end
        axw(motion_ready_pkg::OFF_PARAM, 32'h1234abcd, rOk);
        runSwitch <= 1'b1;
        cyc(8);
        axr(aStat, 32'h3, rOk);
        axw(motion_ready_pkg::OFF_PARAM, 32'h0, rErr);
        axr(motion_ready_pkg::OFF_PARAM, 32'h1234abcd, rOk);
        axr(8'h40, 32'h0, rErr);
        axw(aStart, 32'hff, rErr);
        goReq <= 8'h04;
        cyc(1);
        goReq <= 8'h00;
        cyc(2);
        speedZeroHalt <= 8'h04;
        stopMidway <= 8'h04;
        cyc(1);
        speedZeroHalt <= 8'h00;
        stopMidway <= 8'h00;
        axr(aStart, 32'h04, rOk);
        cyc(30);
        axr(aStart, 32'h0, rOk);
        handwheelAxisMap <= 8'h20;
        for (int k = 0; k < 3; k++) begin
            for (int on = 1; on >= 0; on--) begin
                case (k)
                    0: forward_jog_cmd[4] <= on[0];
                    1: handwheel_enable_flags[0] <= on[0];
                    default: valueChangeBusy[6] <= on[0];
                endcase
                cyc(4);
                axr(aStart, on[0] ? (32'h10 << k) : 32'h0, rOk);
            end
        end
        runSwitch <= 1'b0;
        cyc(6);
        axr(aStat, 32'h0, rOk);
        axw(aCtrl, 32'h1, rOk);
        runSwitch <= 1'b1;
        cyc(6);
        axr(aStat, 32'h0, rOk);
        axw(aWord, 32'h1, rOk);
        axr(aStat, 32'h3, rOk);
        axw(aWord, 32'h0, rOk);
        axr(aStat, 32'h0, rOk);
        axw(aCtrl, 32'h3, rOk);
        axw(aWord, 32'h1, rOk);
        axr(aStat, 32'h9, rOk);
        chk(motionPermit, 1'b0);
        axw(aCtrl, 32'h1, rOk);
        axr(aStat, 32'h3, rOk);
        chk(motionPermit, 1'b1);
        axw(aWord, 32'h0, rOk);
        tbMoving <= 8'h01;
        axw(aWord, 32'h1, rOk);
        axr(motion_ready_pkg::OFF_ERR, 32'h1, rOk);
        axr(aStat, 32'h1, rOk);
        tbMoving <= 8'h00;
        axw(aCtrl, 32'h9, rOk);
        axr(motion_ready_pkg::OFF_ERR, 32'h0, rOk);
        auxCodePending <= 1'b1;
        cyc(3);
        chk(auxCodeOutStatus, 1'b0);
        axw(aCtrl, 32'h5, rOk);
        cyc(3);
        chk(auxCodeOutStatus, 1'b1);
        // a second reset with the switch at run must arm again by itself
        rst_n <= 1'b0;
        cyc(3);
        rst_n <= 1'b1;
        cyc(1);
        chk(fullyClosedReq, 8'h00);
        cyc(8);
        axr(aStat, 32'h3, rOk);
        cyc(4);
        closeOut();
    end
endmodule : test_motion_ready_and_start_accept
`default_nettype wire
